// [verilog/coupler_startup.sv]
// Module: power-up sequencer and switch-driven parameter loader with register slave
`timescale 1ns/1ps

// Function
// - After power-on, self test components and terminal bus, red I/O indicator blinking.
// - Then test terminals, read configuration, build a structure list kept internal.
// - Any startup error sends the sequencer to the stop state.
// - Error-free startup ends in the fieldbus start state.
// - Stop state is left only by a fresh power-on reset.
// - Parameter mode only when the end terminal alone is fitted; else normal settings.
// - All switches ON: restore defaults; error lit, run/error I/O alternate.
// - Controller variant: switches 1-9 ON, 10 OFF deletes boot project; alternate flash.
// - All switches OFF: enter link setup with run and error I/O lit steadily.
// - Switch 1 picks line rate: OFF 10 MBaud, ON 100 MBaud, default 100.
// - Switch 2 picks automatic rate detection: OFF disabled, ON enabled, default on.
// - Switch 3 picks duplex: OFF half, ON full, default full.
// - Switch 10 ON commits link settings; store them and flash both I/O indicators.
module coupler_startup #(
    parameter int unsigned BLINK_HALF = coupler_pkg::BLINK_CYC,
    parameter bit          IS_CTRL    = 1'b0
) (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          ce,
    input  wire logic [coupler_pkg::NUM_SW-1:0] sw_pin,
    input  wire logic                          selftest_done,
    input  wire logic                          selftest_err,
    input  wire logic                          term_done,
    input  wire logic                          term_err,
    input  wire logic                          term_cfg_valid,
    input  wire logic [coupler_pkg::CFG_W-1:0]  term_cfg_data,
    input  wire logic                          nv_done,
    input  wire logic                          nv_err,
    output coupler_pkg::nv_cmd_type            nv_cmd,
    output logic                               nv_req,
    output logic                               link_rate_100,
    output logic                               link_auto,
    output logic                               link_full,
    output logic                               fieldbus_run,
    output logic                               led_io_run,
    output logic                               led_io_err,
    output logic                               led_err,
    input  wire logic [coupler_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    output logic                               irq
);
    import coupler_pkg::*;

    state_type               state;
    state_type               next_state;
    logic [NUM_SW-1:0]       sw_meta;
    logic [NUM_SW-1:0]       sw_sync;
    logic [NUM_SW-1:0]       sw_cap;
    logic [CNT_W-1:0]        term_count;
    logic [CFG_W-1:0]        struct_list [LIST_DEPTH];
    logic [NUM_EV-1:0]       events;
    logic [NUM_EV-1:0]       irq_status;
    logic [NUM_EV-1:0]       irq_enable;
    logic                    blank;
    logic [31:0]             rd_value;
    logic                    wr_hit;
    logic                    commit;
    led_ctrl_if              leds ();

    function automatic logic is_end_only(input logic [CNT_W-1:0] cnt);
        return cnt == '0;
    endfunction : is_end_only

    // ****************************************************************
    // Switch pins into the clock domain
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sw_meta <= '0;
            sw_sync <= '0;
        end else if (ce) begin
            sw_meta <= sw_pin;
            sw_sync <= sw_meta;
        end
    end

    // Switch image frozen once the terminal scan finishes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sw_cap <= '0;
        end else if (ce && state == ST_TERMTEST && term_done) begin
            sw_cap <= sw_sync;
        end
    end

    // ****************************************************************
    // Terminal structure list
    // ****************************************************************
    // Not visible on the bus on purpose; only the count is reported
    always_ff @(posedge clk) begin
        if (!rstn) begin
            term_count <= '0;
        end else if (ce && state == ST_TERMTEST && term_cfg_valid) begin
            if (term_count != CNT_MAX) begin
                term_count <= term_count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && state == ST_TERMTEST && term_cfg_valid && term_count < CNT_W'(LIST_DEPTH)) begin
            struct_list[term_count[$clog2(LIST_DEPTH)-1:0]] <= term_cfg_data;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    assign commit = sw_sync[SW_COMMIT];

    always_comb begin
        next_state = state;
        unique case (state)
            ST_SELFTEST: begin
                if (selftest_done) begin
                    next_state = selftest_err ? ST_STOP : ST_TERMTEST;
                end
            end
            ST_TERMTEST: begin
                if (term_done) begin
                    next_state = term_err ? ST_STOP : ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                if (!is_end_only(term_count)) begin
                    next_state = ST_FIELDBUS;
                end else if (sw_cap == SW_ALL_ON) begin
                    next_state = ST_NV_WAIT;
                end else if (sw_cap == SW_BOOTDEL && IS_CTRL) begin
                    next_state = ST_NV_WAIT;
                end else if (sw_cap == SW_ALL_OFF) begin
                    next_state = ST_LINK_SETUP;
                end else begin
                    next_state = ST_FIELDBUS;
                end
            end
            ST_LINK_SETUP: begin
                if (commit) begin
                    next_state = ST_NV_WAIT;
                end
            end
            ST_NV_WAIT: begin
                if (nv_done) begin
                    next_state = nv_err ? ST_STOP : ST_PARAM_OK;
                end
            end
            ST_PARAM_OK:  next_state = ST_PARAM_OK;
            ST_FIELDBUS:  next_state = ST_FIELDBUS;
            ST_STOP:      next_state = ST_STOP;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ST_SELFTEST;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Fieldbus start flag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fieldbus_run <= 1'b0;
        end else if (ce) begin
            fieldbus_run <= next_state == ST_FIELDBUS;
        end
    end

    // ****************************************************************
    // Non-volatile store requests
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            nv_req <= 1'b0;
            nv_cmd <= NV_NONE;
        end else if (ce) begin
            if (state == ST_NV_WAIT && nv_done) begin
                nv_req <= 1'b0;
            end else if (state == ST_DECIDE && next_state == ST_NV_WAIT) begin
                nv_req <= 1'b1;
                nv_cmd <= (sw_cap == SW_ALL_ON) ? NV_FACTORY : NV_BOOTDEL;
            end else if (state == ST_LINK_SETUP && commit) begin
                nv_req <= 1'b1;
                nv_cmd <= NV_LINK;
            end
        end
    end

    // Link settings, taken live from switches 1-3 at the commit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            {link_full, link_auto, link_rate_100} <= LINK_RST;
        end else if (ce && state == ST_LINK_SETUP && commit) begin
            link_rate_100 <= sw_sync[SW_RATE];
            link_auto     <= sw_sync[SW_AUTO];
            link_full     <= sw_sync[SW_DUPLEX];
        end
    end

    // ****************************************************************
    // Indicators
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            leds.mode <= LED_TEST;
        end else if (ce) begin
            unique case (next_state)
                ST_SELFTEST:   leds.mode <= LED_TEST;
                ST_TERMTEST,
                ST_DECIDE,
                ST_NV_WAIT:    leds.mode <= LED_OFF;
                ST_LINK_SETUP: leds.mode <= LED_STEADY;
                ST_PARAM_OK: begin
                    unique case (nv_cmd)
                        NV_FACTORY: leds.mode <= LED_ALT_ERR;
                        NV_LINK:    leds.mode <= LED_FLASH;
                        default:    leds.mode <= LED_ALT;
                    endcase
                end
                ST_FIELDBUS:   leds.mode <= LED_RUN;
                ST_STOP:       leds.mode <= LED_STOP;
            endcase
        end
    end

    assign leds.blank = blank;

    led_driver #(
        .HALF_CYC (BLINK_HALF)
    ) u_led (
        .clk    (clk),
        .rstn   (rstn),
        .ce     (ce),
        .leds   (leds.drv),
        .io_run (led_io_run),
        .io_err (led_io_err),
        .err    (led_err)
    );

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    always_comb begin
        events              = '0;
        events[EV_STOP]     = state != ST_STOP && next_state == ST_STOP;
        events[EV_FIELDBUS] = state != ST_FIELDBUS && next_state == ST_FIELDBUS;
        events[EV_PARAM]    = state != ST_PARAM_OK && next_state == ST_PARAM_OK;
        events[EV_LINK]     = state == ST_LINK_SETUP && commit;
    end

    assign wr_hit = avs_write && !avs_waitrequest;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_status <= '0;
        end else if (ce) begin
            if (wr_hit && avs_address == OFS_IRQ_CLEAR) begin
                irq_status <= (irq_status & ~avs_writedata[NUM_EV-1:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // ****************************************************************
    // Register slave
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_enable <= IRQ_EN_RST;
            blank      <= 1'b0;
        end else if (ce && wr_hit) begin
            if (avs_address == OFS_IRQ_ENABLE) begin
                irq_enable <= avs_writedata[NUM_EV-1:0];
            end
            if (avs_address == OFS_CONTROL) begin
                blank <= avs_writedata[CTRL_BLANK];
            end
        end
    end

    always_comb begin
        rd_value = '0;
        unique case (avs_address)
            OFS_STATUS: begin
                rd_value[STAT_STATE_LSB +: 4]      = 4'(state);
                rd_value[STAT_COUNT_LSB +: CNT_W]  = term_count;
                rd_value[STAT_SW_LSB +: NUM_SW]    = sw_cap;
            end
            OFS_LINK:       rd_value[2:0] = {link_full, link_auto, link_rate_100};
            OFS_IRQ_STATUS: rd_value[NUM_EV-1:0] = irq_status;
            OFS_IRQ_ENABLE: rd_value[NUM_EV-1:0] = irq_enable;
            OFS_CONTROL:    rd_value[CTRL_BLANK] = blank;
            default:        rd_value = '0;
        endcase
    end

    // One wait cycle on every access; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else if (ce) begin
            if (!avs_waitrequest) begin
                avs_waitrequest <= 1'b1;
            end else if (avs_read || avs_write) begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= rd_value;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence seq_end_only_decide;
        state == ST_DECIDE && is_end_only(term_count) && ce;
    endsequence

    sequence seq_nv_ok;
        state == ST_NV_WAIT && nv_done && !nv_err && ce;
    endsequence

    AST_SELFTEST_LED: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_SELFTEST |-> leds.mode == LED_TEST)
        else $error("indicator not blinking during self test");

    AST_STOP_ON_ERR: assert property (@(posedge clk) disable iff (!rstn)
        ce && ((state == ST_SELFTEST && selftest_done && selftest_err) ||
               (state == ST_TERMTEST && term_done && term_err)) |=> state == ST_STOP)
        else $error("startup error did not stop");

    AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_STOP |=> state == ST_STOP [*4])
        else $error("stop state left without reset");

    AST_NORMAL_START: assert property (@(posedge clk) disable iff (!rstn)
        ce && state == ST_DECIDE && !is_end_only(term_count) |=> ##1 fieldbus_run)
        else $error("no fieldbus start with terminals fitted");

    AST_FACTORY: assert property (@(posedge clk) disable iff (!rstn)
        seq_end_only_decide and (sw_cap == SW_ALL_ON) |=> nv_req && nv_cmd == NV_FACTORY)
        else $error("factory restore not requested");

    AST_BOOTDEL: assert property (@(posedge clk) disable iff (!rstn)
        seq_end_only_decide and (sw_cap == SW_BOOTDEL) |=>
            (IS_CTRL ? (nv_cmd == NV_BOOTDEL && nv_req) : state == ST_FIELDBUS))
        else $error("boot project delete handled wrongly");

    AST_LINK_ENTRY: assert property (@(posedge clk) disable iff (!rstn)
        seq_end_only_decide and (sw_cap == SW_ALL_OFF) |=> state == ST_LINK_SETUP ##1
            (!ce || led_io_run && led_io_err || blank))
        else $error("link setup not entered with steady indicators");

    AST_COMMIT: assert property (@(posedge clk) disable iff (!rstn)
        ce && state == ST_LINK_SETUP && commit |=> nv_req && nv_cmd == NV_LINK &&
            link_rate_100 == $past(sw_sync[SW_RATE]) && link_full == $past(sw_sync[SW_DUPLEX]))
        else $error("link settings not committed");

    AST_SUCCESS_LED: assert property (@(posedge clk) disable iff (!rstn)
        seq_nv_ok |=> leds.mode == (nv_cmd == NV_FACTORY ? LED_ALT_ERR :
                                   nv_cmd == NV_LINK ? LED_FLASH : LED_ALT))
        else $error("wrong success pattern");

    AST_SW_FROZEN: assert property (@(posedge clk) disable iff (!rstn)
        state != ST_TERMTEST && $past(state) != ST_TERMTEST |-> $stable(sw_cap))
        else $error("switch image changed after sampling");

    AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (!rstn)
        ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus access not answered");

endmodule : coupler_startup

// [verilog/coupler_pkg.sv]
// Package: constants, types and register map of the coupler start-up controller
package coupler_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ   = 100;
    localparam int BLINK_MS  = 250;
    localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam int          ADDR_W         = 5;
    localparam logic [4:0]  OFS_STATUS     = 5'h00;
    localparam logic [4:0]  OFS_LINK       = 5'h04;
    localparam logic [4:0]  OFS_IRQ_STATUS = 5'h08;
    localparam logic [4:0]  OFS_IRQ_CLEAR  = 5'h0c;
    localparam logic [4:0]  OFS_IRQ_ENABLE = 5'h10;
    localparam logic [4:0]  OFS_CONTROL    = 5'h14;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_COUNT_LSB = 8;
    localparam int STAT_SW_LSB    = 16;
    // Control register fields
    localparam int CTRL_BLANK     = 0;

    // ****************************************************************
    // Events and interrupts
    // ****************************************************************
    localparam int NUM_EV      = 4;
    localparam int EV_STOP     = 0;
    localparam int EV_FIELDBUS = 1;
    localparam int EV_PARAM    = 2;
    localparam int EV_LINK     = 3;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;

    // ****************************************************************
    // Switches, terminals, link settings
    // ****************************************************************
    localparam int          NUM_SW      = 10;
    localparam int          SW_RATE     = 0;
    localparam int          SW_AUTO     = 1;
    localparam int          SW_DUPLEX   = 2;
    localparam int          SW_COMMIT   = 9;
    localparam logic [9:0]  SW_ALL_ON   = 10'h3ff;
    localparam logic [9:0]  SW_BOOTDEL  = 10'h1ff;
    localparam logic [9:0]  SW_ALL_OFF  = 10'h000;
    localparam int          CFG_W       = 8;
    localparam int          LIST_DEPTH  = 16;
    localparam int          CNT_W       = 8;
    localparam logic [7:0]  CNT_MAX     = 8'hff;
    localparam logic [2:0]  LINK_RST    = 3'h7;

    typedef enum logic [1:0] {
        NV_NONE, NV_FACTORY, NV_BOOTDEL, NV_LINK
    } nv_cmd_type;

    typedef enum logic [3:0] {
        ST_SELFTEST, ST_TERMTEST, ST_DECIDE, ST_NV_WAIT,
        ST_LINK_SETUP, ST_PARAM_OK, ST_FIELDBUS, ST_STOP
    } state_type;

    typedef enum logic [2:0] {
        LED_OFF, LED_TEST, LED_RUN, LED_STOP, LED_ALT, LED_ALT_ERR, LED_STEADY, LED_FLASH
    } led_mode_type;

endpackage : coupler_pkg

// [verilog/led_ctrl_if.sv]
// Interface: indicator pattern request from sequencer to indicator driver
`timescale 1ns/1ps
interface led_ctrl_if;
    import coupler_pkg::*;
    led_mode_type mode;
    logic         blank;
    modport ctrl (output mode, output blank);
    modport drv  (input mode, input blank);
endinterface : led_ctrl_if

// [verilog/led_driver.sv]
// Module: indicator pattern generator (blink, alternate and steady patterns)
`timescale 1ns/1ps
module led_driver #(
    parameter int unsigned HALF_CYC = coupler_pkg::BLINK_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    led_ctrl_if.drv   leds,
    output logic      io_run,
    output logic      io_err,
    output logic      err
);
    import coupler_pkg::*;

    localparam int CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] count;
    logic          phase;

    // ****************************************************************
    // Pattern timebase
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count <= '0;
            phase <= 1'b0;
        end else if (ce) begin
            if (count == LAST) begin
                count <= '0;
                phase <= !phase;
            end else begin
                count <= count + CW'(1);
            end
        end
    end

    // ****************************************************************
    // Patterns
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            io_run <= 1'b0;
            io_err <= 1'b0;
            err    <= 1'b0;
        end else if (ce) begin
            io_run <= 1'b0;
            io_err <= 1'b0;
            err    <= 1'b0;
            if (!leds.blank) begin
                unique case (leds.mode)
                    LED_OFF:     ;
                    LED_TEST:    io_err <= phase;
                    LED_RUN:     io_run <= 1'b1;
                    LED_STOP: begin
                        io_err <= 1'b1;
                        err    <= 1'b1;
                    end
                    LED_ALT: begin
                        io_run <= phase;
                        io_err <= !phase;
                    end
                    LED_ALT_ERR: begin
                        io_run <= phase;
                        io_err <= !phase;
                        err    <= 1'b1;
                    end
                    LED_STEADY: begin
                        io_run <= 1'b1;
                        io_err <= 1'b1;
                    end
                    LED_FLASH: begin
                        io_run <= phase;
                        io_err <= phase;
                    end
                endcase
            end
        end
    end

endmodule : led_driver

// [sim/term_model.sv]
// Partner model: self-test unit, terminal scan and parameter store
`timescale 1ns/1ps
module term_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] n_terms,
    input  wire logic [2:0] fault,
    input  wire logic       nv_req,
    output logic            selftest_done,
    output logic            selftest_err,
    output logic            term_done,
    output logic            term_err,
    output logic            term_cfg_valid,
    output logic [7:0]      term_cfg_data,
    output logic            nv_done,
    output logic            nv_err
);
    logic [9:0] step;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            step <= 10'h000;
        end else if (step != 10'h3ff) begin
            step <= step + 10'h001;
        end
    end
    // Self test ends late enough to watch the blink
    assign selftest_done  = (step == 10'h014);
    assign selftest_err   = selftest_done & fault[2];
    assign term_cfg_valid = (step > 10'h018) && (step <= 10'h018 + n_terms);
    assign term_done      = (step == 10'h019 + n_terms);
    assign term_err       = term_done & fault[1];
    // Changes every cycle until step saturates at 10'h3ff, so stale data never looks valid
    assign term_cfg_data  = step[7:0];
    always_ff @(posedge clk) begin
        nv_done <= rstn & nv_req & ~nv_done;
    end
    assign nv_err = nv_done & fault[0];
endmodule : term_model

// [sim/tb_coupler_startup.sv]
// Testbench: power-up sequence, switch modes and register access
`timescale 1ns/1ps
module tb_coupler_startup;
    import coupler_pkg::*;
    logic clk, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, b;
    logic [9:0] sw_pin = 10'h000;
    logic [7:0] n_terms = 8'h00, term_cfg_data;
    logic [2:0] fault = 3'h0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
    logic selftest_done, selftest_err, term_done, term_err, term_cfg_valid, nv_done, nv_err;
    logic nv_req, link_rate_100, link_auto, link_full, fieldbus_run, irq;
    logic led_io_run, led_io_err, led_err, avs_waitrequest;
    nv_cmd_type nv_cmd;
    int fail_count = 0, checks_done = 0;
    localparam logic [9:0] SWT [7] = '{10'h000, 10'h000, 10'h000, 10'h3ff, 10'h1ff, 10'h3ff, 10'h005};
    localparam logic [7:0] NTS [7] = '{8'h03, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [2:0] FLT [7] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h0, 3'h1, 3'h0};
    localparam logic [3:0] STT [7] = '{4'h6, 4'h7, 4'h7, 4'h5, 4'h5, 4'h7, 4'h6};
    coupler_startup #(.BLINK_HALF(4), .IS_CTRL(1'b1)) dut (.clk, .rstn, .ce(1'b1), .sw_pin,
        .selftest_done, .selftest_err, .term_done, .term_err, .term_cfg_valid, .term_cfg_data,
        .nv_done, .nv_err, .nv_cmd, .nv_req, .link_rate_100, .link_auto, .link_full,
        .fieldbus_run, .led_io_run, .led_io_err, .led_err, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
    term_model partner (.clk, .rstn, .n_terms, .fault, .nv_req, .selftest_done, .selftest_err,
        .term_done, .term_err, .term_cfg_valid, .term_cfg_data, .nv_done, .nv_err);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic bus(logic w, logic [4:0] a, logic [31:0] v);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= w;
        avs_read <= !w;
        // No cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic power(logic [9:0] s, logic [7:0] n, logic [2:0] f);
        rstn <= 1'b0;
        sw_pin <= s;
        n_terms <= n;
        fault <= f;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        b = led_io_err;
        repeat (4) @(posedge clk);
        chk("blink", {31'h0, ~b}, {31'h0, led_io_err});
    endtask : power
    task automatic expect_state(logic [3:0] e);
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rdat[3:0] !== e && n < 60);
        chk("state", {28'h0, e}, {28'h0, rdat[3:0]});
    endtask : expect_state
    task automatic print_verdict;
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
    initial begin
        for (int i = 0; i < 7; i++) begin
            power(SWT[i], NTS[i], FLT[i]);
            expect_state(STT[i]);
            chk("count", {24'h0, NTS[i]}, {24'h0, rdat[15:8]});
            repeat (30) @(posedge clk);
            expect_state(STT[i]);
            chk("run", {31'h0, STT[i] == 4'h6}, {31'h0, fieldbus_run});
            chk("err", {31'h0, STT[i] == 4'h7 || SWT[i] == 10'h3ff}, {31'h0, led_err});
            if (STT[i] == 4'h5) begin
                chk("alt", {31'h0, ~led_io_err}, {31'h0, led_io_run});
            end
        end
        power(10'h000, 8'h00, 3'h0);
        expect_state(4'h4);
        chk("steady", 32'h3, {30'h0, led_io_run, led_io_err});
        bus(1'b1, OFS_IRQ_ENABLE, 32'h8);
        sw_pin <= 10'h005;
        bus(1'b0, OFS_LINK, 32'h0);
        chk("link hold", 32'h7, rdat);
        chk("irq idle", 32'h0, {31'h0, irq});
        sw_pin <= 10'h202;
        expect_state(4'h5);
        chk("link", 32'h2, {29'h0, link_full, link_auto, link_rate_100});
        chk("irq", 32'h1, {31'h0, irq});
        b = led_io_run;
        repeat (4) @(posedge clk);
        chk("flash", {30'h0, ~b, ~b}, {30'h0, led_io_run, led_io_err});
        bus(1'b1, OFS_IRQ_CLEAR, 32'hf);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("clear", 32'h0, rdat);
        bus(1'b0, 5'h1c, 32'h0);
        chk("unmapped", 32'h0, rdat);
        bus(1'b1, OFS_CONTROL, 32'h1);
        bus(1'b0, OFS_CONTROL, 32'h0);
        chk("blank", 32'h1, rdat);
        chk("dark", 32'h0, {29'h0, led_io_run, led_io_err, led_err});
        print_verdict();
    end
endmodule : tb_coupler_startup
